// ---- bench/sram_host_properties.sv ----
// Checker of the host's pin sequencing toward the static memory.
`default_nettype none
module sram_host_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] word_select_lines,
  input wire logic first_select_n,
  input wire logic second_select_n,
  input wire logic out_gate_n,
  input wire logic read_write,
  input wire logic [3:0] shared_data_lines_o,
  input wire logic shared_data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_q;

  // Counts sampled cycles with the write strobe low; a pulse must last sixteen cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 8'h00;
    end else if (!read_write) begin
      low_q <= low_q + 8'h01;
    end else begin
      low_q <= 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_selects_together: assert property (first_select_n == second_select_n)
    else $error("selects differ");
  a_write_selected: assert property (!read_write |->
    !first_select_n && !shared_data_lines_oe_n)
    else $error("write strobe without select or data");
  a_addr_steady: assert property ((!read_write || $rose(read_write)) |->
    $stable(word_select_lines))
    else $error("address moved around write");
  a_data_hold: assert property ((!read_write || $rose(read_write)) |->
    !shared_data_lines_oe_n && $stable(shared_data_lines_o))
    else $error("write data not held");
  a_gate_write: assert property (!shared_data_lines_oe_n |->
    out_gate_n && $past(out_gate_n, 4))
    else $error("gate low while host drives");
  a_pulse_width: assert property ($fell(read_write) |-> !read_write [*8])
    else $error("write pulse too short");
  a_pulse_long: assert property ($rose(read_write) |-> low_q >= 8'h10)
    else $error("write pulse under sixteen cycles");
  a_read_quiet: assert property (!out_gate_n |->
    !first_select_n && read_write && shared_data_lines_oe_n)
    else $error("gate open outside a read");
endmodule
bind sram_host sram_host_properties chk (.clk(clk), .rst(rst),
  .word_select_lines(word_select_lines), .first_select_n(first_select_n),
  .second_select_n(second_select_n), .out_gate_n(out_gate_n), .read_write(read_write),
  .shared_data_lines_o(shared_data_lines_o), .shared_data_lines_oe_n(shared_data_lines_oe_n));
`default_nettype wire

// ---- bench/sram_model.sv ----
// Behavioural model of the 256 by 4 static memory on the far side.
`default_nettype none
module sram_model (
  input wire logic [7:0] word_select_lines,
  input wire logic first_select_n,
  input wire logic second_select_n,
  input wire logic out_gate_n,
  input wire logic read_write,
  input wire logic [3:0] dq_in,
  output logic drive,
  output logic [3:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [256];
  logic en;
  assign en = !first_select_n && !second_select_n;
  assign drive = en && !out_gate_n;
  assign dq_out = mem[word_select_lines];
  always @* begin
    if (en && !read_write) mem[word_select_lines] = dq_in;
  end
endmodule
`default_nettype wire

// ---- bench/static_ram_256x4_common_io_tb.sv ----
// Self-checking bench of the static memory host controller.
`default_nettype none
module static_ram_256x4_common_io_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic [7:0] req_addr = 8'h00;
  logic [3:0] req_wdata = 4'h0;
  logic req_ready, rsp_valid, sel1_n, sel2_n, gate_n, rw, oe_n, drive;
  logic [3:0] rsp_rdata, host_o, mem_o, wire_q, last_q = 4'h0;
  logic [7:0] addr;
  logic [7:0] at [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  logic [3:0] dt [4] = '{4'h5, 4'ha, 4'h3, 4'hc};
  int fails = 0, n_checks = 0, cycles = 0;
  always #25 clk = ~clk;
  sram_host DUT (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_select_lines(addr),
    .first_select_n(sel1_n), .second_select_n(sel2_n), .out_gate_n(gate_n),
    .read_write(rw), .shared_data_lines_i(wire_q), .shared_data_lines_o(host_o),
    .shared_data_lines_oe_n(oe_n));
  sram_model mem (.word_select_lines(addr), .first_select_n(sel1_n),
    .second_select_n(sel2_n), .out_gate_n(gate_n), .read_write(rw), .dq_in(wire_q),
    .drive(drive), .dq_out(mem_o));
  // An undriven wire shows a changing pattern rather than its last value.
  always @* wire_q = !oe_n ? host_o : drive ? mem_o : ~last_q;
  always @(posedge clk) begin
    last_q <= wire_q;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic req(input logic w, input logic [7:0] a, input logic [3:0] d);
    while (req_ready !== 1'b1) @(negedge clk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    int i;
    req(1'b0, a, 4'h0);
    for (i = 0; i < 60 && rsp_valid !== 1'b1; i++) @(negedge clk);
    check(rsp_valid === 1'b1 && rsp_rdata === e, "read data wrong");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    check(sel1_n === 1'b1 && sel2_n === 1'b1 && rw === 1'b1, "idle pins");
    check(gate_n === 1'b1 && oe_n === 1'b1 && req_ready === 1'b1, "idle state");
    check(rsp_valid === 1'b0 && addr === 8'h00, "idle answer");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 4; i++) req(1'b1, at[i], dt[i]);
    for (int i = 0; i < 4; i++) rd(at[i], dt[i]);
  endtask
  task automatic t_reread();
    repeat (200) @(negedge clk);
    rd(8'h80, 4'h3);
    rd(8'h80, 4'h3);
  endtask
  task automatic t_overwrite();
    req(1'b1, 8'h01, 4'hf);
    rd(8'h01, 4'hf);
    rd(8'h00, 4'h5);
    rd(8'hff, 4'hc);
  endtask
  // A reset during write setup must return the pins to idle and leave the word intact.
  task automatic t_reset();
    req(1'b1, 8'h00, 4'h9);
    @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    t_idle();
    rd(8'h00, 4'h5);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 0;
    t_idle();
    t_fill();
    t_reread();
    t_overwrite();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire

// ---- design/phase_timer.sv ----
// Down counter that times each phase of a memory access.
`default_nettype none
module phase_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] count,
  output logic expired
);
  logic [7:0] left_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= 8'h00;
    end else if (load) begin
      left_q <= count;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // Expired looks at the count alone, since the load is itself decided from it.
  assign expired = (left_q == 8'h00);
endmodule
`default_nettype wire

// ---- design/sram_host.sv ----
// Host controller that drives a 256 by 4 static memory with shared data lines.
`include "sram_host_defs.svh"
`default_nettype none
// Behaviour
// RULE1: Present one of 256 word addresses on the eight word-select lines.
// RULE2: Enable device by driving both active-low selects low together.
// RULE3: Device ignores writes and floats data while any select is high.
// RULE4: Read/write line high for reads, low only while writing.
// RULE5: Read/write back high before address changes, held for a hold interval.
// RULE6: Device drives read data only while output gate is low.
// RULE7: Write data valid setup before and hold after read/write rise.
// RULE8: Device takes input only while writing with both selects low.
// RULE9: Device drives data only with both selects and gate low.
// RULE10: Read returns the stored bits unchanged and uninverted.
// RULE11: No refresh or clock is needed to keep stored words.
// RULE12: Host drives data only after output-disable delay has passed.
// RULE13: Output gate stays high throughout every write access.
module sram_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [3:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_rdata,
  output logic [7:0] word_select_lines,
  output logic first_select_n,
  output logic second_select_n,
  output logic out_gate_n,
  output logic read_write,
  input wire logic [3:0] shared_data_lines_i,
  output logic [3:0] shared_data_lines_o,
  output logic shared_data_lines_oe_n
);
  import sram_host_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [3:0] data_meta_q;
  logic [3:0] data_sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_meta_q <= 4'h0;
      data_sync_q <= 4'h0;
    end else begin
      data_meta_q <= shared_data_lines_i;
      data_sync_q <= data_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  host_state_t state_q;
  host_state_t state_d;
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_done;

  phase_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_done)
  );

  // Timer loads on every state change with the length of the new phase.
  always_comb begin
    state_d = state_q;
    tmr_count = 8'h00;
    case (state_q)
      st_idle: begin
        if (req_valid) begin
          state_d = req_write ? st_wr_setup : st_rd_setup;
          tmr_count = 8'(`ADDR_SETUP_CYC);
        end
      end
      st_rd_setup: begin
        if (tmr_done) begin
          state_d = st_rd_wait;
          // Two extra cycles cover the input synchroniser.
          tmr_count = 8'(`ACCESS_CYC + 2);
        end
      end
      st_rd_wait: begin
        if (tmr_done) begin
          state_d = st_rd_done;
        end
      end
      st_rd_done: begin
        state_d = st_release;
        // Release waits out the output-disable delay before the host may drive again.
        tmr_count = 8'(`OUT_DIS_CYC); // RULE12
      end
      st_wr_setup: begin
        if (tmr_done) begin
          state_d = st_wr_pulse;
          tmr_count = 8'(`WR_PULSE_CYC);
        end
      end
      st_wr_pulse: begin
        if (tmr_done) begin
          state_d = st_wr_hold;
          tmr_count = 8'(`DATA_HOLD_CYC + `WR_REST_CYC);
        end
      end
      st_wr_hold: begin
        if (tmr_done) begin
          state_d = st_idle;
        end
      end
      st_release: begin
        if (tmr_done) begin
          state_d = st_idle;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  assign tmr_load = (state_d != state_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Requests are taken only between accesses, so address and write data never change mid-access.
  assign req_ready = (state_q == st_idle);

  // ----------------------------------------------------------------
  // State decoding
  // ----------------------------------------------------------------
  // Read phases keep the memory selected with its output gate open.
  function automatic logic in_read(input host_state_t s);
    return (s == st_rd_setup) || (s == st_rd_wait) || (s == st_rd_done);
  endfunction

  // Write phases, hold included, are those in which the host drives the data lines.
  function automatic logic in_write(input host_state_t s);
    return (s == st_wr_setup) || (s == st_wr_pulse) || (s == st_wr_hold);
  endfunction

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  logic [7:0] addr_q;
  logic [3:0] wdata_q;
  logic sel_n_q;
  logic gate_n_q;
  logic rw_q;
  logic oe_n_q;

  // Address and write data latch only when idle, so they never move mid-access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 8'h00;
      wdata_q <= 4'h0;
    end else if (req_valid && req_ready) begin
      addr_q <= req_addr; // RULE1 RULE5
      wdata_q <= req_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_n_q <= 1'b1;
      gate_n_q <= 1'b1;
      rw_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      sel_n_q <= !(in_read(state_d) || state_d == st_wr_setup ||
                   state_d == st_wr_pulse); // RULE2 RULE3
      gate_n_q <= !in_read(state_d); // RULE6 RULE9 RULE13
      rw_q <= (state_d != st_wr_pulse); // RULE4 RULE5 RULE8
      // Host drives data through setup, pulse and hold, never during release.
      oe_n_q <= !in_write(state_d); // RULE7 RULE12
    end
  end

  assign word_select_lines = addr_q;
  // Both selects share one flop, so they can never differ.
  assign first_select_n = sel_n_q;
  assign second_select_n = sel_n_q;
  assign out_gate_n = gate_n_q;
  assign read_write = rw_q;
  assign shared_data_lines_o = wdata_q;
  assign shared_data_lines_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  logic rsp_valid_q;
  logic [3:0] rdata_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rdata_q <= 4'h0;
    end else begin
      rsp_valid_q <= (state_q == st_rd_done);
      // Read data is captured from the second synchroniser stage in the done phase.
      if (state_q == st_rd_done) begin
        rdata_q <= data_sync_q; // RULE10 RULE11
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
endmodule
`default_nettype wire

// ---- pkg/sram_host_defs.svh ----
// Timing constants for the static memory host controller.
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

`define CLK_PERIOD_NS 50
`define ADDR_W 8
`define DATA_W 4
`define WORD_COUNT 256
// Slowest grade figures, in ns.
`define T_RD_CYCLE_NS 1000
`define T_WR_CYCLE_NS 1000
`define T_WR_PULSE_NS 800
`define T_ADDR_SETUP_NS 150
`define T_SEL_SETUP_NS 900
`define T_DATA_SETUP_NS 700
`define T_ADDR_HOLD_NS 50
`define T_DATA_HOLD_NS 100
`define T_ACCESS_NS 1000
`define T_OUT_DIS_NS 200
// Least times round up to whole cycles.
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC `CYC(`T_RD_CYCLE_NS)
`define ACCESS_CYC `CYC(`T_ACCESS_NS)
`define ADDR_SETUP_CYC `CYC(`T_ADDR_SETUP_NS)
`define WR_PULSE_CYC `CYC(`T_WR_PULSE_NS + `T_SEL_SETUP_NS - `T_WR_PULSE_NS)
`define DATA_HOLD_CYC `CYC(`T_DATA_HOLD_NS)
`define ADDR_HOLD_CYC `CYC(`T_ADDR_HOLD_NS)
`define OUT_DIS_CYC `CYC(`T_OUT_DIS_NS)
`define WR_REST_CYC `CYC(`T_WR_CYCLE_NS - `T_ADDR_SETUP_NS - `T_SEL_SETUP_NS)

`endif

// ---- pkg/sram_host_pkg.sv ----
// Types for the static memory host controller.
`default_nettype none
package sram_host_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_rd_setup = 3'b001,
    st_rd_wait = 3'b010,
    st_rd_done = 3'b011,
    st_wr_setup = 3'b100,
    st_wr_pulse = 3'b101,
    st_wr_hold = 3'b110,
    st_release = 3'b111
  } host_state_t;
endpackage
`default_nettype wire
